//--- verilog/acd_pkg.sv
// Constants and types of the SPI command decoder of the delta-sigma converter.
// Assumes a framing block that turns SPI frames into 16-bit payload words and strobes.
// Contract
// - All-zero or unknown word changes nothing and answers with the status word.
// - Reset word is taken at frame end, then registers return to defaults.
// - Completed reset answers FF23h; unfinished reset frame answers 0011h, no reset.
// - Standby word at frame end enters standby; no effect when already standby.
// - Resume word leaves standby; no effect when already converting.
// - Lock word locks; then only no-op, read and unlock act; data continues.
// - Unlock word leaves the locked state.
// - Answers come next frame; standby, resume, lock, unlock echo their word.
// - Read word is 101, six-bit address, seven-bit count minus one.
// - Count zero read answers one word with the addressed register.
// - Count above zero sends 111 header echo, then registers ascending.
// - Frame answering a multi-register read carries no conversion data.
// - Write word is 011, address, count minus one; data words follow.
// - Each written word commits on arrival; input CRC mismatch sets CRC error.
// - Writes to read-only or absent addresses are dropped and not counted.
// - Write answers 010, start address, registers actually written minus one.
// - Payload is 16 bits, MSB aligned in the word; default word is 24 bits.
// - Failed input CRC blocks the command, except register writes which execute.
// - CRC error flag clears once the status word has been sent.
package acd_pkg;
   localparam int REG_COUNT = 64;
   localparam logic [15:0] CMD_NULL = 16'h0000;
   localparam logic [15:0] CMD_RESET = 16'h0011;
   localparam logic [15:0] CMD_STANDBY = 16'h0022;
   localparam logic [15:0] CMD_RESUME = 16'h0033;
   localparam logic [15:0] CMD_LOCK = 16'h0555;
   localparam logic [15:0] CMD_UNLOCK = 16'h0655;
   localparam logic [2:0] PFX_READ = 3'h5;
   localparam logic [2:0] PFX_WRITE = 3'h3;
   localparam logic [2:0] PFX_READ_HDR = 3'h7;
   localparam logic [2:0] PFX_WRITE_ACK = 3'h2;
   localparam logic [15:0] RESP_RESET_DONE = 16'hFF23;
   localparam logic [15:0] RESP_RESET_CUT = 16'h0011;
   localparam logic [5:0] DREG_ID = 6'h00;
   localparam logic [5:0] DREG_STATUS = 6'h01;
   localparam int STAT_LOCK_BIT = 15;
   localparam int STAT_CRC_BIT = 12;
   localparam int STAT_STANDBY_BIT = 10;
   localparam logic [7:0] AXI_CTRL = 8'h00;
   localparam logic [7:0] AXI_STATE = 8'h04;
   localparam logic [7:0] AXI_LAST_CMD = 8'h08;
   localparam int CTRL_CRC_EN_BIT = 0;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      RK_STATUS = 2'b00,
      RK_WORD = 2'b01,
      RK_READ = 2'b10
   } acd_resp_kind_type;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_CMD = 2'b01,
      PH_DATA = 2'b10,
      PH_REST = 2'b11
   } acd_phase_type;

   typedef struct packed {
      acd_resp_kind_type kind;
      logic [15:0] word;
      logic [5:0] addr;
      logic [6:0] count;
   } acd_resp_type;

   typedef struct packed {
      logic start;
      logic done;
      logic abort;
      logic rx_valid;
      logic [15:0] rx_word;
      logic crc_valid;
      logic crc_ok;
      logic tx_req;
   } acd_link_in_type;

   typedef struct packed {
      logic tx_valid;
      logic [15:0] tx_word;
      logic tx_last;
      logic suppress_conv;
      logic rx_crc_enable;
   } acd_link_out_type;
endpackage : acd_pkg

//--- verilog/acd_decoder.sv
// Command decoder: interprets command words of each frame and forms next frame's answers.
// Assumes the framing block strobes words in frame order and handles width and CRC math.
`timescale 1ns/10ps
module acd_decoder #(
   parameter logic [acd_pkg::REG_COUNT-1:0] WRITABLE = 64'hFFFF_FFFF_FFFF_FFFC,
   parameter logic [acd_pkg::REG_COUNT*16-1:0] REG_DEFAULT = '0,
   parameter logic [15:0] DEVICE_ID = 16'h0A5A // Value is arbitrary.
) (
   input wire logic core_clk, // 25 MHz clock.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic s_axi_awvalid, // Write address valid.
   output logic s_axi_awready, // Write address ready.
   input wire logic [7:0] s_axi_awaddr, // Write byte address.
   input wire logic s_axi_wvalid, // Write data valid.
   output logic s_axi_wready, // Write data ready.
   input wire logic [31:0] s_axi_wdata, // Write data.
   input wire logic [3:0] s_axi_wstrb, // Write byte enables.
   output logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   output logic [1:0] s_axi_bresp, // Write response code.
   input wire logic s_axi_arvalid, // Read address valid.
   output logic s_axi_arready, // Read address ready.
   input wire logic [7:0] s_axi_araddr, // Read byte address.
   output logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready, // Read data ready.
   output logic [31:0] s_axi_rdata, // Read data.
   output logic [1:0] s_axi_rresp, // Read response code.
   input wire acd_pkg::acd_link_in_type link_in, // Frame strobes and words.
   output acd_pkg::acd_link_out_type link_out, // Answer words to the framer.
   output logic standby, // Device in standby.
   output logic locked, // Interface locked.
   output logic soft_reset // One-cycle pulse after a reset command.
);
   typedef struct packed {
      logic [acd_pkg::REG_COUNT-1:0][15:0] regs;
      logic crc_err;
      logic standby;
      logic locked;
      logic soft_reset;
      acd_pkg::acd_phase_type phase;
      logic [15:0] cmd;
      logic [15:0] last_cmd;
      logic [6:0] widx;
      logic [6:0] nwritten;
      logic crc_bad;
      acd_pkg::acd_resp_type pend;
      acd_pkg::acd_resp_type cur;
      logic [7:0] tx_idx;
      acd_pkg::acd_link_out_type link;
      logic [31:0] ctrl;
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } acd_state_type;

   acd_state_type s;
   acd_state_type next_s;

   // Status bits 15, 12 and 10 carry lock, CRC error and standby.
   function automatic logic [15:0] status_word(input acd_state_type st);
      logic [15:0] w;
      w = 16'h0000;
      w[acd_pkg::STAT_LOCK_BIT] = st.locked;
      w[acd_pkg::STAT_CRC_BIT] = st.crc_err;
      w[acd_pkg::STAT_STANDBY_BIT] = st.standby;
      return w;
   endfunction : status_word

   // Addresses 0 and 1 are read-only views built from other state.
   function automatic logic [15:0] reg_value(input acd_state_type st, input logic [5:0] a);
      logic [15:0] v;
      v = st.regs[a];
      if (a == acd_pkg::DREG_ID) begin
         v = DEVICE_ID;
      end else if (a == acd_pkg::DREG_STATUS) begin
         v = status_word(st);
      end
      return v;
   endfunction : reg_value

   always_comb begin
      logic [5:0] waddr;
      logic [5:0] raddr;
      logic [15:0] c;
      logic blocked;
      logic is_write;
      logic [7:0] last_idx;
      waddr = 6'h00;
      raddr = 6'h00;
      c = s.cmd;
      blocked = 1'b0;
      is_write = 1'b0;
      // Header is word 0, so the last register word is count plus one.
      last_idx = {1'b0, s.cur.count} + 8'h01;
      next_s = s;
      next_s.link.tx_valid = 1'b0;
      next_s.soft_reset = 1'b0;
      // The framer checks input CRC only while this bit is set.
      next_s.link.rx_crc_enable = s.ctrl[acd_pkg::CTRL_CRC_EN_BIT];

      // Answer words belong to the response chosen in the previous frame.
      if (link_in.start) begin
         next_s.cur = s.pend;
         next_s.tx_idx = 8'h00;
         next_s.link.suppress_conv = (s.pend.kind == acd_pkg::RK_READ)
            && (s.pend.count != 7'h00);
         next_s.phase = acd_pkg::PH_CMD;
         next_s.cmd = acd_pkg::CMD_NULL;
         next_s.crc_bad = 1'b0;
         next_s.widx = 7'h00;
         next_s.nwritten = 7'h00;
         // A frame without a done strobe answers with status by default.
         next_s.pend.kind = acd_pkg::RK_STATUS;
      end

      if (link_in.tx_req) begin
         next_s.link.tx_valid = 1'b1;
         next_s.link.tx_last = 1'b1;
         next_s.link.tx_word = 16'h0000;
         // The index sticks at FFh, so extra requests read zero words.
         if (s.tx_idx != 8'hFF) begin
            next_s.tx_idx = s.tx_idx + 8'h01;
         end
         case (s.cur.kind)
            acd_pkg::RK_STATUS: begin
               if (s.tx_idx == 8'h00) begin
                  next_s.link.tx_word = status_word(s);
                  next_s.crc_err = 1'b0;
               end
            end
            acd_pkg::RK_WORD: begin
               if (s.tx_idx == 8'h00) begin
                  next_s.link.tx_word = s.cur.word;
               end
            end
            acd_pkg::RK_READ: begin
               if (s.cur.count == 7'h00) begin
                  if (s.tx_idx == 8'h00) begin
                     next_s.link.tx_word = reg_value(s, s.cur.addr);
                  end
               end else if (s.tx_idx == 8'h00) begin
                  next_s.link.tx_word = {acd_pkg::PFX_READ_HDR, s.cur.addr, s.cur.count};
                  next_s.link.tx_last = 1'b0;
               end else if (s.tx_idx <= last_idx) begin
                  raddr = s.cur.addr + s.tx_idx[5:0] - 6'h01;
                  next_s.link.tx_word = reg_value(s, raddr);
                  next_s.link.tx_last = (s.tx_idx == last_idx);
               end
            end
            default: begin
               next_s.link.tx_word = 16'h0000;
            end
         endcase
      end

      // Words arrive 16-bit MSB payload only; the framer strips word padding.
      if (link_in.rx_valid) begin
         case (s.phase)
            acd_pkg::PH_CMD: begin
               next_s.cmd = link_in.rx_word;
               next_s.last_cmd = link_in.rx_word;
               // A locked interface skips the data phase, so data words are ignored.
               if (link_in.rx_word[15:13] == acd_pkg::PFX_WRITE && !s.locked) begin
                  next_s.phase = acd_pkg::PH_DATA;
               end else begin
                  next_s.phase = acd_pkg::PH_REST;
               end
            end
            acd_pkg::PH_DATA: begin
               // Addresses wrap in six bits past 63.
               waddr = s.cmd[12:7] + s.widx[5:0];
               if (WRITABLE[waddr]) begin
                  next_s.regs[waddr] = link_in.rx_word;
                  next_s.nwritten = s.nwritten + 7'h01;
               end
               next_s.widx = s.widx + 7'h01;
               if (s.widx == s.cmd[6:0]) begin
                  next_s.phase = acd_pkg::PH_REST;
               end
            end
            default: begin
               next_s.phase = s.phase;
            end
         endcase
      end

      // Placed after the status send so a new error wins over the clear.
      if (link_in.crc_valid && !link_in.crc_ok && s.ctrl[acd_pkg::CTRL_CRC_EN_BIT]) begin
         next_s.crc_bad = 1'b1;
         next_s.crc_err = 1'b1;
      end

      // A cut frame's command never runs, but write words already stored stay; a cut reset has its own answer.
      if (link_in.abort && s.phase != acd_pkg::PH_IDLE) begin
         next_s.phase = acd_pkg::PH_IDLE;
         if (s.phase != acd_pkg::PH_CMD && c == acd_pkg::CMD_RESET) begin
            next_s.pend.kind = acd_pkg::RK_WORD;
            next_s.pend.word = acd_pkg::RESP_RESET_CUT;
         end else begin
            next_s.pend.kind = acd_pkg::RK_STATUS;
         end
      end else if (link_in.done && s.phase != acd_pkg::PH_IDLE) begin
         next_s.phase = acd_pkg::PH_IDLE;
         blocked = s.crc_bad
            || (link_in.crc_valid && !link_in.crc_ok && s.ctrl[acd_pkg::CTRL_CRC_EN_BIT]);
         is_write = (c[15:13] == acd_pkg::PFX_WRITE) && !s.locked
            && (s.phase != acd_pkg::PH_CMD);
         next_s.pend.kind = acd_pkg::RK_STATUS;
         next_s.pend.addr = c[12:7];
         next_s.pend.count = c[6:0];
         // Writes run despite bad CRC, as their words are already stored.
         if (is_write) begin
            next_s.pend.kind = acd_pkg::RK_WORD;
            // With no word written the count field wraps to 7Fh.
            next_s.pend.word = {acd_pkg::PFX_WRITE_ACK, c[12:7], s.nwritten - 7'h01};
         end else if (blocked || s.phase == acd_pkg::PH_CMD) begin
            next_s.pend.kind = acd_pkg::RK_STATUS;
         end else if (c[15:13] == acd_pkg::PFX_READ) begin
            next_s.pend.kind = acd_pkg::RK_READ;
         end else if (c == acd_pkg::CMD_UNLOCK) begin
            next_s.locked = 1'b0;
            next_s.pend.kind = acd_pkg::RK_WORD;
            next_s.pend.word = c;
         end else if (s.locked) begin
            next_s.pend.kind = acd_pkg::RK_STATUS;
         end else begin
            case (c)
               acd_pkg::CMD_RESET: begin
                  // The bus control word survives a command reset.
                  next_s.regs = REG_DEFAULT;
                  next_s.standby = 1'b0;
                  next_s.crc_err = 1'b0;
                  next_s.soft_reset = 1'b1;
                  next_s.pend.kind = acd_pkg::RK_WORD;
                  next_s.pend.word = acd_pkg::RESP_RESET_DONE;
               end
               acd_pkg::CMD_STANDBY: begin
                  next_s.standby = 1'b1;
                  next_s.pend.kind = acd_pkg::RK_WORD;
                  next_s.pend.word = c;
               end
               acd_pkg::CMD_RESUME: begin
                  next_s.standby = 1'b0;
                  next_s.pend.kind = acd_pkg::RK_WORD;
                  next_s.pend.word = c;
               end
               acd_pkg::CMD_LOCK: begin
                  next_s.locked = 1'b1;
                  next_s.pend.kind = acd_pkg::RK_WORD;
                  next_s.pend.word = c;
               end
               default: begin
                  next_s.pend.kind = acd_pkg::RK_STATUS;
               end
            endcase
         end
      end

      // AXI4-Lite slave: address and data are caught in either order.
      if (s_axi_awvalid && s.awready) begin
         next_s.aw_got = 1'b1;
         next_s.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.wready) begin
         next_s.w_got = 1'b1;
         next_s.w_data = s_axi_wdata;
         next_s.w_strb = s_axi_wstrb;
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end
      if (s.aw_got && s.w_got && !s.bvalid) begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = acd_pkg::AXI_OKAY;
         if (s.aw_addr[7:2] == acd_pkg::AXI_CTRL[7:2]) begin
            // Only byte 0 of the control word is kept.
            if (s.w_strb[0]) begin
               next_s.ctrl[7:0] = s.w_data[7:0];
            end
         end else if (s.aw_addr[7:2] != acd_pkg::AXI_STATE[7:2]
                      && s.aw_addr[7:2] != acd_pkg::AXI_LAST_CMD[7:2]) begin
            next_s.bresp = acd_pkg::AXI_SLVERR;
         end
      end
      // Ready stays low while a write is held or answered.
      next_s.awready = !next_s.aw_got && !next_s.bvalid;
      next_s.wready = !next_s.w_got && !next_s.bvalid;

      if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
      // Bus status reads never clear the CRC error flag.
      if (s_axi_arvalid && s.arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = acd_pkg::AXI_OKAY;
         next_s.rdata = 32'h0000_0000;
         case (s_axi_araddr[7:2])
            acd_pkg::AXI_CTRL[7:2]: next_s.rdata = {24'h000000, s.ctrl[7:0]};
            acd_pkg::AXI_STATE[7:2]: next_s.rdata = {16'h0000, status_word(s)};
            acd_pkg::AXI_LAST_CMD[7:2]: next_s.rdata = {16'h0000, s.last_cmd};
            default: next_s.rresp = acd_pkg::AXI_SLVERR;
         endcase
      end
      next_s.arready = !next_s.rvalid;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s <= '0;
         // Pin reset restores the register defaults, not zeros.
         s.regs <= REG_DEFAULT;
      end else begin
         s <= next_s;
      end
   end

   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = s.arready;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign link_out = s.link;
   assign standby = s.standby;
   assign locked = s.locked;
   assign soft_reset = s.soft_reset;
endmodule : acd_decoder

//--- testbench/acd_props.sv
// Checker of the command decoder's link-side behaviour, bound to the decoder top.
// Assumes framer strobes follow the hand-over contract: command first, CRC before done.
`timescale 1ns/10ps
module acd_props (
   input wire logic core_clk, // Decoder clock.
   input wire logic rst, // Asynchronous reset.
   input wire acd_pkg::acd_link_in_type link_in, // Framer strobes.
   input wire acd_pkg::acd_link_out_type link_out, // Answer words.
   input wire logic standby, // Standby level.
   input wire logic locked, // Lock level.
   input wire logic soft_reset // Reset pulse.
);
   logic [15:0] cmd_q;
   logic got_cmd;
   logic crc_bad;
   logic ok;

   // Only the first word of a frame is the command; later words are write data.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cmd_q <= 16'h0000;
         got_cmd <= 1'b0;
         crc_bad <= 1'b0;
      end else if (link_in.start) begin
         cmd_q <= 16'h0000;
         got_cmd <= 1'b0;
         crc_bad <= 1'b0;
      end else begin
         if (link_in.rx_valid && !got_cmd) begin
            cmd_q <= link_in.rx_word;
            got_cmd <= 1'b1;
         end
         if (link_in.crc_valid && !link_in.crc_ok && link_out.rx_crc_enable) begin
            crc_bad <= 1'b1;
         end
      end
   end
   assign ok = !crc_bad;

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   a_answer_next: assert property (link_in.tx_req |=> link_out.tx_valid)
      else $error("answer word missing after request");
   a_valid_cause: assert property (link_out.tx_valid |-> $past(link_in.tx_req))
      else $error("answer word without request");
   a_header_quiet: assert property (link_out.tx_valid && link_out.tx_word[15:13] ==
      acd_pkg::PFX_READ_HDR && link_out.tx_word != acd_pkg::RESP_RESET_DONE
      |-> link_out.suppress_conv)
      else $error("read header frame carries conversion data");
   a_standby_enter: assert property (link_in.done && cmd_q == acd_pkg::CMD_STANDBY && ok
      && !locked |-> ##[1:2] standby)
      else $error("standby not entered");
   a_resume_leave: assert property (link_in.done && cmd_q == acd_pkg::CMD_RESUME && ok
      && !locked |-> ##[1:2] !standby)
      else $error("standby not left");
   a_lock_enter: assert property (link_in.done && cmd_q == acd_pkg::CMD_LOCK && ok
      |-> ##[1:2] locked)
      else $error("lock not entered");
   a_unlock_leave: assert property (link_in.done && cmd_q == acd_pkg::CMD_UNLOCK && ok
      |-> ##[1:2] !locked)
      else $error("lock not left");
   a_reset_pulse: assert property (link_in.done && cmd_q == acd_pkg::CMD_RESET && ok
      && !locked |-> ##[1:2] soft_reset)
      else $error("reset command did not reset");
   a_cut_no_reset: assert property (link_in.abort && cmd_q == acd_pkg::CMD_RESET
      |=> !soft_reset [*3])
      else $error("cut reset frame reset the device");
   a_lock_refuse: assert property (locked && link_in.done && cmd_q == acd_pkg::CMD_STANDBY
      |=> $stable(standby) [*2])
      else $error("standby changed while locked");
   a_crc_blocks: assert property (link_in.done && cmd_q == acd_pkg::CMD_LOCK && !ok
      && !locked |=> !locked [*2])
      else $error("command ran despite input CRC failure");

   c_multi_read: cover property (link_out.tx_valid && link_out.suppress_conv);
   c_soft_reset: cover property (soft_reset);
   c_lock: cover property ($rose(locked));
endmodule : acd_props

//--- testbench/acd_host_model.sv
// Partner model: the framer and host that turn SPI frames into decoder strobes.
// Assumes the decoder answers a word request one cycle later.
`timescale 1ns/10ps
module acd_host_model (
   input wire logic core_clk, // Decoder clock.
   output acd_pkg::acd_link_in_type link_in, // Strobes to the decoder.
   input wire acd_pkg::acd_link_out_type link_out // Answers from the decoder.
);
   logic [15:0] got [8];
   logic lst [8];
   logic sup;

   initial link_in = '0;

   function automatic acd_pkg::acd_link_in_type mk(input int k, input logic [15:0] w);
      mk = '0;
      mk.rx_word = w;
      mk.crc_ok = w[0];
      case (k)
         0: mk.start = 1'b1;
         1: mk.rx_valid = 1'b1;
         2: mk.crc_valid = 1'b1;
         3: mk.done = 1'b1;
         4: mk.abort = 1'b1;
         default: mk.tx_req = 1'b1;
      endcase
   endfunction : mk

   // Each strobe lasts one cycle and an idle cycle follows, a slow but legal pace.
   task automatic pulse(input acd_pkg::acd_link_in_type v);
      @(posedge core_clk);
      link_in <= v;
      @(posedge core_clk);
      link_in <= '0;
   endtask : pulse

   task automatic frame(input logic [15:0] cmd, input int nd, input logic [15:0] d0,
         input logic bad, input int ntx, input logic cut);
      pulse(mk(0, 16'h0000));
      for (int i = 0; i < ntx; i++) begin
         pulse(mk(5, 16'h0000));
         #1;
         got[i] = link_out.tx_word;
         lst[i] = link_out.tx_last;
         sup = link_out.suppress_conv;
      end
      pulse(mk(1, cmd));
      for (int i = 0; i < nd; i++) pulse(mk(1, d0 + 16'(i)));
      pulse(mk(2, {15'h0000, !bad}));
      pulse(mk(cut ? 4 : 3, 16'h0000));
   endtask : frame
endmodule : acd_host_model

//--- testbench/tb.sv
// Testbench of the command decoder: bus cases, a table of frames, then multi-read and reset cases.
// Assumes the host model drives the link and the checker is bound at the foot.
`timescale 1ns/10ps
module tb;
   localparam logic [15:0] ID = 16'h0C3C; // Value is arbitrary.
   localparam int SETTLE = 8; // Register settle delay in cycles, a plain default.
   typedef struct packed {
      logic [15:0] cmd;
      logic [1:0] nd;
      logic [15:0] d0;
      logic bad;
      logic [15:0] exp;
   } acd_row_type;
   logic core_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic standby, locked, soft_reset;
   logic [15:0] prev;
   acd_pkg::acd_link_in_type link_in;
   acd_pkg::acd_link_out_type link_out;
   int err_count, n_compared;
   acd_row_type rows [24] = '{
      '{16'h0000, 2'h0, 16'h0000, 1'b0, 16'h0000}, '{16'h6100, 2'h1, 16'h0000, 1'b0, 16'h4100},
      '{16'h0022, 2'h0, 16'h0000, 1'b0, 16'h0022}, '{16'h0000, 2'h0, 16'h0000, 1'b0, 16'h0400},
      '{16'h0022, 2'h0, 16'h0000, 1'b0, 16'h0022}, '{16'h0033, 2'h0, 16'h0000, 1'b0, 16'h0033},
      '{16'h6100, 2'h1, 16'h0001, 1'b0, 16'h4100}, '{16'h0033, 2'h0, 16'h0000, 1'b0, 16'h0033},
      '{16'h0000, 2'h0, 16'h0000, 1'b0, 16'h0000}, '{16'h6101, 2'h2, 16'h1234, 1'b0, 16'h4101},
      '{16'h6002, 2'h3, 16'hABC0, 1'b0, 16'h4000}, '{16'hA100, 2'h0, 16'h0000, 1'b0, 16'hABC2},
      '{16'hA000, 2'h0, 16'h0000, 1'b0, ID}, '{16'h0555, 2'h0, 16'h0000, 1'b0, 16'h0555},
      '{16'h0022, 2'h0, 16'h0000, 1'b0, 16'h8000}, '{16'h6100, 2'h1, 16'h5555, 1'b0, 16'h8000},
      '{16'h0555, 2'h0, 16'h0000, 1'b0, 16'h8000}, '{16'hA100, 2'h0, 16'h0000, 1'b0, 16'hABC2},
      '{16'h0655, 2'h0, 16'h0000, 1'b0, 16'h0655}, '{16'h6200, 2'h1, 16'h7777, 1'b1, 16'h4200},
      '{16'h0000, 2'h0, 16'h0000, 1'b0, 16'h1000}, '{16'h0555, 2'h0, 16'h0000, 1'b1, 16'h1000},
      '{16'hA200, 2'h0, 16'h0000, 1'b0, 16'h7777}, '{16'h00FF, 2'h0, 16'h0000, 1'b0, 16'h0000}};

   acd_decoder #(.DEVICE_ID(ID)) DUT (.core_clk, .rst, .s_axi_awvalid, .s_axi_awready,
      .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
      .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
      .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .link_in, .link_out,
      .standby, .locked, .soft_reset);
   acd_host_model host (.core_clk, .link_in, .link_out);

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         err_count++;
      end
   endtask : chk

   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude

   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axw

   task automatic axr(input logic [7:0] a);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axr

   // The whole run needs under a thousand cycles; this allows about five thousand.
   initial begin
      #200000;
      err_count++;
      conclude();
   end

   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      rst = 1'b1;
      err_count = 0;
      n_compared = 0;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      axw(acd_pkg::AXI_CTRL, 32'h0000_0001);
      chk(rs, acd_pkg::AXI_OKAY);
      axr(acd_pkg::AXI_CTRL);
      chk(rd, 32'h0000_0001);
      chk(link_out.rx_crc_enable, 1'b1);
      axw(8'h40, 32'h0000_0001);
      chk(rs, acd_pkg::AXI_SLVERR);
      axr(8'h40);
      chk(rs, acd_pkg::AXI_SLVERR);
      axw(acd_pkg::AXI_STATE, 32'h0000_FFFF);
      chk(rs, acd_pkg::AXI_OKAY);
      axr(acd_pkg::AXI_STATE);
      chk(rd, 32'h0000_0000);
      prev = 16'h0000;
      // Rows 1 and 6 clear, then set, converter_enable in register 2.
      foreach (rows[i]) begin
         host.frame(rows[i].cmd, rows[i].nd, rows[i].d0, rows[i].bad, 1, 1'b0);
         chk(host.got[0], prev);
         prev = rows[i].exp;
      end
      host.frame(16'hA101, 0, 16'h0000, 1'b0, 1, 1'b0);
      chk(host.got[0], prev);
      host.frame(16'h0555, 0, 16'h0000, 1'b0, 3, 1'b0);
      chk(host.got[0], 16'hE101);
      chk(host.got[1], 16'hABC2);
      chk(host.got[2], 16'h1235);
      chk(host.lst[2], 1'b1);
      chk(host.sup, 1'b1);
      axr(acd_pkg::AXI_STATE);
      chk(rd, 32'h0000_8000);
      axr(acd_pkg::AXI_LAST_CMD);
      chk(rd, 32'h0000_0555);
      host.frame(16'h0655, 0, 16'h0000, 1'b0, 1, 1'b0);
      chk(host.got[0], 16'h0555);
      host.frame(acd_pkg::CMD_RESET, 0, 16'h0000, 1'b0, 1, 1'b1);
      chk(host.got[0], 16'h0655);
      host.frame(16'hA100, 0, 16'h0000, 1'b0, 1, 1'b0);
      chk(host.got[0], acd_pkg::RESP_RESET_CUT);
      host.frame(acd_pkg::CMD_RESET, 0, 16'h0000, 1'b0, 1, 1'b0);
      chk(host.got[0], 16'hABC2);
      repeat (SETTLE) @(posedge core_clk);
      host.frame(16'hA100, 0, 16'h0000, 1'b0, 1, 1'b0);
      chk(host.got[0], acd_pkg::RESP_RESET_DONE);
      host.frame(16'h0000, 0, 16'h0000, 1'b0, 1, 1'b0);
      chk(host.got[0], 16'h0000);
      conclude();
   end
endmodule : tb

bind acd_decoder acd_props u_props (.core_clk(core_clk), .rst(rst), .link_in(link_in),
   .link_out(link_out), .standby(standby), .locked(locked), .soft_reset(soft_reset));
